// *** design/drc_defines.svh ***
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define DRC_CLK_NS 4

// ----------------------------------------
// array geometry
// ----------------------------------------
`define DRC_ADDR_W 16
`define DRC_HALF_W 8
`define DRC_ROWS 256
`define DRC_INIT_CYCLES 4'h8
`define DRC_SYNC_CYC 2

// ----------------------------------------
// times in ns (refresh period in ms, power-up wait in us)
// ----------------------------------------
`define DRC_T_RAC_NS 150
`define DRC_T_CAC_NS 85
`define DRC_T_RCD_NS 25
`define DRC_T_RP_NS 100
`define DRC_T_RAS_MIN_NS 150
`define DRC_T_RAS_MAX_NS 10000
`define DRC_T_CP_NS 40
`define DRC_T_WP_NS 60
`define DRC_T_WCH_NS 60
`define DRC_T_REF_MS 4
`define DRC_T_PWR_US 100

// ----------------------------------------
// cycle counts (least rounds up except power-up wait, which rounds down; longest rounds down)
// ----------------------------------------
`define DRC_CYC_UP(ns) (((ns) + `DRC_CLK_NS - 1) / `DRC_CLK_NS)
`define DRC_RAC_CYC `DRC_CYC_UP(`DRC_T_RAC_NS)
`define DRC_CAC_CYC `DRC_CYC_UP(`DRC_T_CAC_NS)
`define DRC_RCD_CYC `DRC_CYC_UP(`DRC_T_RCD_NS)
`define DRC_RP_CYC `DRC_CYC_UP(`DRC_T_RP_NS)
`define DRC_RAS_MIN_CYC `DRC_CYC_UP(`DRC_T_RAS_MIN_NS)
`define DRC_RAS_MAX_CYC (`DRC_T_RAS_MAX_NS / `DRC_CLK_NS)
`define DRC_CP_CYC `DRC_CYC_UP(`DRC_T_CP_NS)
`define DRC_WP_CYC `DRC_CYC_UP(`DRC_T_WP_NS)
`define DRC_WCH_CYC `DRC_CYC_UP(`DRC_T_WCH_NS)
`define DRC_REF_ROW_CYC ((`DRC_T_REF_MS * 1000000) / (`DRC_ROWS * `DRC_CLK_NS))
`define DRC_PWR_CYC ((`DRC_T_PWR_US * 1000) / `DRC_CLK_NS)

`endif

// *** design/drc_host.sv ***
// Behaviour
// - row half driven on address lines, latched by row strobe falling
// - column half driven next on same lines, latched by column strobe falling
// - address lines stable no later than the latching strobe edge
// - early write: write-select low before column strobe falls
// - all 256 rows strobed by row strobe within every 4 ms
// - refresh uses row-strobe-only cycles, column strobe kept high
// - after power-up row strobe high 100 us, then eight row cycles
// - page mode: row kept open while successive columns are strobed
`timescale 1ns/100ps
`default_nettype none
`include "drc_defines.svh"

module drc_host
    import drc_pkg::*;
#(
    parameter int PWR_CYC = `DRC_PWR_CYC,
    parameter int REF_ROW_CYC = `DRC_REF_ROW_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // user request
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic reqRmw,
    input wire logic [15:0] reqAddr,
    input wire logic reqData,
    // user answer
    output logic rspValid,
    output logic rspData,
    // memory pins
    output logic rasN,
    output logic casN,
    output logic wN,
    output logic [7:0] multiplexedAddressLines,
    output logic dataIn,
    input wire logic dataOut
);

    drc_state_e state_reg, state_next;
    drc_count_t cnt_reg, cnt_next;
    logic [11:0] rasCnt_reg, rasCnt_next;
    logic rasN_reg, rasN_next, casN_reg, casN_next, wN_reg, wN_next;
    logic [7:0] addr_reg, addr_next, refRow_reg, refRow_next;
    logic dIn_reg, dIn_next, rsp_reg, rsp_next, rspD_reg, rspD_next;
    logic [15:0] rAddr_reg, rAddr_next;
    logic rWrite_reg, rWrite_next, rRmw_reg, rRmw_next, rData_reg, rData_next;
    logic [3:0] refPend_reg, refPend_next, initLeft_reg, initLeft_next;
    logic refMode_reg, refMode_next;
    logic qMeta_reg, qSync_reg;
    logic refTick, idleOk, pageOk, refDone;

    function automatic logic [7:0] rowOf(input logic [15:0] a);
        rowOf = a[15:8];
    endfunction

    function automatic logic [7:0] colOf(input logic [15:0] a);
        colOf = a[7:0];
    endfunction

    // ----------------------------------------
    // refresh timing
    // ----------------------------------------
    drc_tick #(.PERIOD(REF_ROW_CYC)) refTimer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable(state_reg != ST_PWR && initLeft_reg == 4'h0),
        .tick(refTick)
    );

    // ----------------------------------------
    // request acceptance
    // ----------------------------------------
    assign idleOk = state_reg == ST_IDLE && initLeft_reg == 4'h0 && refPend_reg == 4'h0;
    assign pageOk = state_reg == ST_CASUP && cnt_reg >= drc_count_t'(`DRC_CP_CYC)
        && !refMode_reg && refPend_reg == 4'h0
        && rasCnt_reg < 12'(`DRC_RAS_MAX_CYC - 64)
        && rowOf(reqAddr) == rowOf(rAddr_reg);
    assign reqReady = idleOk || pageOk;
    assign refDone = state_reg == ST_REF && rasCnt_reg >= 12'(`DRC_RAS_MIN_CYC);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 16'h0001;
        rasN_next = rasN_reg;
        casN_next = casN_reg;
        wN_next = wN_reg;
        addr_next = addr_reg;
        dIn_next = dIn_reg;
        rsp_next = 1'b0;
        rspD_next = rspD_reg;
        rAddr_next = rAddr_reg;
        rWrite_next = rWrite_reg;
        rRmw_next = rRmw_reg;
        rData_next = rData_reg;
        refRow_next = refRow_reg;
        initLeft_next = initLeft_reg;
        refMode_next = refMode_reg;
        refPend_next = refPend_reg;
        if (refTick && refPend_reg != 4'hF) begin
            refPend_next = refPend_reg + 4'h1;
        end
        rasCnt_next = rasCnt_reg;
        if (!rasN_reg && rasCnt_reg != 12'hFFF) begin
            rasCnt_next = rasCnt_reg + 12'h001;
        end
        if (reqValid && reqReady) begin
            rAddr_next = reqAddr;
            rWrite_next = reqWrite;
            rRmw_next = reqRmw;
            rData_next = reqData;
        end
        case (state_reg)
            ST_PWR: begin
                rasN_next = 1'b1;
                if (cnt_reg >= drc_count_t'(PWR_CYC - 1)) begin
                    initLeft_next = `DRC_INIT_CYCLES;
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (initLeft_reg != 4'h0 || refPend_reg != 4'h0) begin
                    addr_next = refRow_reg;
                    refMode_next = 1'b1;
                    state_next = ST_ROW;
                end else if (reqValid) begin
                    addr_next = rowOf(reqAddr);
                    refMode_next = 1'b0;
                    state_next = ST_ROW;
                end
            end
            ST_ROW: begin
                rasN_next = 1'b0;
                rasCnt_next = 12'h000;
                cnt_next = 16'h0000;
                state_next = refMode_reg ? ST_REF : ST_RCD;
            end
            ST_RCD: begin
                if (cnt_reg >= drc_count_t'(`DRC_RCD_CYC - 1)) begin
                    addr_next = colOf(rAddr_reg);
                    wN_next = !(rWrite_reg && !rRmw_reg);
                    dIn_next = rData_reg;
                    cnt_next = 16'h0000;
                    state_next = ST_CAS;
                end
            end
            ST_CAS: begin
                casN_next = 1'b0;
                if (rWrite_reg && !rRmw_reg) begin
                    if (cnt_reg >= drc_count_t'(`DRC_WCH_CYC + 1)) begin
                        cnt_next = 16'h0000;
                        state_next = ST_CASUP;
                    end
                end else if (cnt_reg >= drc_count_t'(`DRC_CAC_CYC + `DRC_SYNC_CYC + 1)
                        && rasCnt_reg >= 12'(`DRC_RAC_CYC + `DRC_SYNC_CYC)) begin
                    rsp_next = 1'b1;
                    rspD_next = qSync_reg;
                    cnt_next = 16'h0000;
                    if (rRmw_reg) begin
                        wN_next = 1'b0;
                        state_next = ST_RMW;
                    end else begin
                        state_next = ST_CASUP;
                    end
                end
            end
            ST_RMW: begin
                if (cnt_reg >= drc_count_t'(`DRC_WP_CYC)) begin
                    cnt_next = 16'h0000;
                    state_next = ST_CASUP;
                end
            end
            ST_CASUP: begin
                casN_next = 1'b1;
                wN_next = 1'b1;
                if (reqValid && pageOk) begin
                    addr_next = colOf(reqAddr);
                    wN_next = !(reqWrite && !reqRmw);
                    dIn_next = reqData;
                    cnt_next = 16'h0000;
                    state_next = ST_CAS;
                end else if (cnt_reg >= drc_count_t'(`DRC_CP_CYC)
                        && rasCnt_reg >= 12'(`DRC_RAS_MIN_CYC)) begin
                    rasN_next = 1'b1;
                    cnt_next = 16'h0000;
                    state_next = ST_PRE;
                end
            end
            ST_REF: begin
                casN_next = 1'b1;
                if (refDone) begin
                    rasN_next = 1'b1;
                    refRow_next = refRow_reg + 8'h01;
                    if (initLeft_reg != 4'h0) begin
                        initLeft_next = initLeft_reg - 4'h1;
                    end else begin
                        refPend_next = refPend_next - 4'h1;
                    end
                    cnt_next = 16'h0000;
                    state_next = ST_PRE;
                end
            end
            ST_PRE: begin
                if (cnt_reg >= drc_count_t'(`DRC_RP_CYC - 1)) begin
                    refMode_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_PWR;
                cnt_next = 16'h0000;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= ST_PWR;
            cnt_reg <= 16'h0000;
            rasCnt_reg <= 12'h000;
            rasN_reg <= 1'b1;
            casN_reg <= 1'b1;
            wN_reg <= 1'b1;
            addr_reg <= 8'h00;
            dIn_reg <= 1'b0;
            rsp_reg <= 1'b0;
            rspD_reg <= 1'b0;
            rAddr_reg <= 16'h0000;
            rWrite_reg <= 1'b0;
            rRmw_reg <= 1'b0;
            rData_reg <= 1'b0;
            refRow_reg <= 8'h00;
            refPend_reg <= 4'h0;
            initLeft_reg <= 4'h0;
            refMode_reg <= 1'b0;
            qMeta_reg <= 1'b0;
            qSync_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            rasCnt_reg <= rasCnt_next;
            rasN_reg <= rasN_next;
            casN_reg <= casN_next;
            wN_reg <= wN_next;
            addr_reg <= addr_next;
            dIn_reg <= dIn_next;
            rsp_reg <= rsp_next;
            rspD_reg <= rspD_next;
            rAddr_reg <= rAddr_next;
            rWrite_reg <= rWrite_next;
            rRmw_reg <= rRmw_next;
            rData_reg <= rData_next;
            refRow_reg <= refRow_next;
            refPend_reg <= refPend_next;
            initLeft_reg <= initLeft_next;
            refMode_reg <= refMode_next;
            qMeta_reg <= dataOut;
            qSync_reg <= qMeta_reg;
        end
    end

    assign rasN = rasN_reg;
    assign casN = casN_reg;
    assign wN = wN_reg;
    assign multiplexedAddressLines = addr_reg;
    assign dataIn = dIn_reg;
    assign rspValid = rsp_reg;
    assign rspData = rspD_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    rowAddr_a: assert property ($fell(rasN) |-> multiplexedAddressLines == $past(addr_reg)
        && (refMode_reg || multiplexedAddressLines == rowOf(rAddr_reg)))
        else $error("row address wrong at row strobe");
    colAddr_a: assert property ($fell(casN) |-> multiplexedAddressLines == colOf(rAddr_reg))
        else $error("column address wrong at column strobe");
    addrSetup_a: assert property (($fell(rasN) || $fell(casN)) |-> $stable(multiplexedAddressLines))
        else $error("address changed at strobe edge");
    earlyWrite_a: assert property ($fell(casN) && rWrite_reg && !rRmw_reg |-> !$past(wN))
        else $error("early write not set before column strobe");
    refreshCas_a: assert property (refMode_reg && !rasN |-> casN)
        else $error("column strobe active in refresh");
    refreshLag_a: assert property (refPend_reg <= 4'h2)
        else $error("refresh fell behind");
    initFirst_a: assert property (reqReady |-> initLeft_reg == 4'h0 && state_reg != ST_PWR)
        else $error("request taken before initialisation");
    pageOpen_a: assert property (pageOk && reqValid |-> ##1 !rasN ##1 !casN)
        else $error("page access closed the row");
    readWhileCas_a: assert property (rspValid && !(rWrite_reg && !rRmw_reg)
        |-> !casN && $past(casN, 3) == 1'b0)
        else $error("read sampled outside column strobe");

    readCov_c: cover property ($fell(casN) && !rWrite_reg ##[1:40] rspValid);
    rmwCov_c: cover property (state_reg == ST_RMW);
    pageCov_c: cover property (pageOk && reqValid);
    refCov_c: cover property (refDone && initLeft_reg == 4'h0);

endmodule

`default_nettype wire

// *** design/drc_pkg.sv ***
package drc_pkg;

    typedef enum logic [3:0] {
        ST_PWR = 4'h0,
        ST_IDLE = 4'h1,
        ST_ROW = 4'h3,
        ST_RCD = 4'h2,
        ST_CAS = 4'h6,
        ST_RMW = 4'h7,
        ST_CASUP = 4'h5,
        ST_PRE = 4'h4,
        ST_REF = 4'hC
    } drc_state_e;

    typedef logic [15:0] drc_count_t;

endpackage

// *** design/drc_tick.sv ***
`timescale 1ns/100ps
`default_nettype none

module drc_tick
    import drc_pkg::*;
#(
    parameter int PERIOD = 3906
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control
    input wire logic enable,
    output logic tick
);

    drc_count_t count_reg;
    drc_count_t count_next;
    logic tick_reg;
    logic tick_next;

    // ----------------------------------------
    // divider
    // ----------------------------------------
    always_comb begin
        count_next = count_reg;
        tick_next = 1'b0;
        if (enable) begin
            if (count_reg == drc_count_t'(PERIOD - 1)) begin
                count_next = 16'h0000;
                tick_next = 1'b1;
            end else begin
                count_next = count_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule

`default_nettype wire

// *** verif/drc_host_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module drc_host_tb_top;
    localparam int PWR = 20;
    localparam int REF = 1500;
    // ------------------------
    // signals
    // ------------------------
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic reqRmw = 1'b0;
    logic [15:0] reqAddr = 16'h0000;
    logic reqData = 1'b0;
    logic reqReady, rspValid, rspData, rasN, casN, wN, dataIn, dataOut, qDrive, initErr;
    logic [7:0] multiplexedAddressLines, rowAtRas, colAtCas, prevRef;
    logic wAtCas, qSeen = 1'b0, refChk = 1'b0, refOk = 1'b1, prevOk = 1'b0;
    logic rspQ [$];
    int fails = 0, numChecks = 0, cycles = 0;
    int rasAcc = 0, rowOnly = 0, casFalls = 0, casSinceRas = 0;
    always #2 sys_clk = ~sys_clk;
    drc_host #(.PWR_CYC(PWR), .REF_ROW_CYC(REF)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reqValid(reqValid), .reqReady(reqReady),
        .reqWrite(reqWrite), .reqRmw(reqRmw), .reqAddr(reqAddr), .reqData(reqData),
        .rspValid(rspValid), .rspData(rspData), .rasN(rasN), .casN(casN), .wN(wN),
        .multiplexedAddressLines(multiplexedAddressLines), .dataIn(dataIn),
        .dataOut(dataOut));
    drc_ram_model #(.PWR_NS(PWR * 4.0), .REF_NS(256.0 * REF * 4.0)) ram (
        .rasN(rasN), .casN(casN), .wN(wN), .dataIn(dataIn), .dataOut(dataOut),
        .multiplexedAddressLines(multiplexedAddressLines), .qDrive(qDrive),
        .initErr(initErr));
    // ------------------------
    // pin monitors
    // ------------------------
    always @(negedge rasN) begin
        rowAtRas = multiplexedAddressLines;
        casSinceRas = 0;
    end
    always @(negedge casN) begin
        colAtCas = multiplexedAddressLines;
        wAtCas = wN;
        casFalls++;
        casSinceRas++;
    end
    always @(posedge rasN) begin
        if (!sys_rst && casSinceRas == 0) begin
            if (refChk && prevOk && rowAtRas !== prevRef + 8'h01) refOk = 1'b0;
            prevRef = rowAtRas;
            prevOk = refChk;
            rowOnly++;
        end else if (!sys_rst) begin
            rasAcc++;
        end
    end
    always @(posedge qDrive) qSeen = 1'b1;
    always @(posedge sys_clk) begin
        if (rspValid === 1'b1) rspQ.push_back(rspData);
        cycles++;
        if (cycles == 30000) begin
            fails++;
            testDone();
        end
    end
    // ------------------------
    // shared tasks
    // ------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic testDone;
        $display("checks %0d fails %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic takeRsp;
        return (rspQ.size() > 0) ? rspQ.pop_front() : 1'bx;
    endfunction
    task automatic send(input logic w, input logic m, input logic [15:0] a, input logic d);
        #1;
        reqValid = 1'b1;
        reqWrite = w;
        reqRmw = m;
        reqAddr = a;
        reqData = d;
        do @(posedge sys_clk); while (reqReady !== 1'b1);
    endtask
    task automatic quiet;
        int n = 0;
        #1 reqValid = 1'b0;
        repeat (3) @(posedge sys_clk);
        while (!(rasN === 1'b1 && reqReady === 1'b1) && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic syncRef;
        int r = rowOnly;
        int n = 0;
        while (rowOnly == r && n < 2 * REF) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic readChk(input logic [15:0] a, input logic e);
        qSeen = 1'b0;
        send(1'b0, 1'b0, a, ~e);
        quiet();
        check("read data", 16'(takeRsp()), 16'(e));
        check("read w", 16'(wAtCas), 16'h0001);
        check("read release", 16'(qDrive), 16'h0000);
    endtask
    // ------------------------
    // scenarios
    // ------------------------
    task automatic test_init;
        int n = 0;
        while (rasN === 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        check("power gap", 16'(n >= PWR), 16'h0001);
        quiet();
        check("init rows", 16'(rowOnly), 16'h0008);
        check("init access", 16'(rasAcc), 16'h0000);
    endtask
    task automatic test_rw;
        logic [15:0] a [5] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'hFF00, 16'h5AA5};
        for (int i = 0; i < 5; i++) begin
            qSeen = 1'b0;
            send(1'b1, 1'b0, a[i], i[0]);
            quiet();
            check("wr row", 16'(rowAtRas), 16'(a[i][15:8]));
            check("wr col", 16'(colAtCas), 16'(a[i][7:0]));
            check("early w", 16'(wAtCas), 16'h0000);
            check("wr float", 16'(qSeen), 16'h0000);
        end
        for (int i = 0; i < 5; i++) begin
            readChk(a[i], i[0]);
            check("rd drive", 16'(qSeen), 16'h0001);
        end
    endtask
    task automatic test_rmw;
        qSeen = 1'b0;
        send(1'b0, 1'b1, 16'h5AA5, 1'b1);
        quiet();
        check("rmw old", 16'(takeRsp()), 16'h0000);
        check("rmw drive", 16'(qSeen), 16'h0001);
        readChk(16'h5AA5, 1'b1);
        readChk(16'h0000, 1'b0);
    endtask
    task automatic test_page;
        int r0;
        int c0;
        syncRef();
        r0 = rasAcc;
        c0 = casFalls;
        for (int i = 0; i < 4; i++) send(1'b1, 1'b0, 16'h3301 + 16'(i), i[1] ^ i[0]);
        quiet();
        for (int i = 0; i < 4; i++) send(1'b0, 1'b0, 16'h3301 + 16'(i), 1'b0);
        quiet();
        check("page rows", 16'(rasAcc - r0), 16'h0002);
        check("page cols", 16'(casFalls - c0), 16'h0008);
        for (int i = 0; i < 4; i++) begin
            check("page data", 16'(takeRsp()), 16'(i[1] ^ i[0]));
        end
    endtask
    task automatic test_refresh;
        int r0;
        int c0;
        syncRef();
        r0 = rowOnly;
        c0 = casFalls;
        qSeen = 1'b0;
        refChk = 1'b1;
        repeat (3 * REF + REF / 2) @(posedge sys_clk);
        refChk = 1'b0;
        check("ref count", 16'(rowOnly - r0), 16'h0003);
        check("ref rows", 16'(refOk), 16'h0001);
        check("ref cas", 16'(casFalls - c0), 16'h0000);
        check("ref float", 16'(qSeen), 16'h0000);
        readChk(16'hFFFF, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        test_init();
        test_rw();
        test_rmw();
        test_page();
        test_refresh();
        check("init order", 16'(initErr), 16'h0000);
        testDone();
    end
endmodule

`default_nettype wire

// *** verif/drc_ram_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module drc_ram_model #(
    parameter real CAC_NS = 85.0,
    parameter real RAC_NS = 150.0,
    parameter real PWR_NS = 80.0,
    parameter real REF_NS = 614400.0
) (
    // strobes and address
    input wire logic rasN,
    input wire logic casN,
    input wire logic wN,
    input wire logic [7:0] multiplexedAddressLines,
    // data pins
    input wire logic dataIn,
    output logic dataOut,
    // observation
    output logic qDrive,
    output logic initErr
);
    // ------------------------
    // cell array and latches
    // ------------------------
    logic mem [0:65535];
    realtime rowT [0:255];
    realtime rasT = 0;
    logic [7:0] rowLat = 8'h00;
    logic [7:0] colLat = 8'h00;
    logic bitOut;
    int rasCnt = 0;
    initial begin
        dataOut = 1'b0;
        qDrive = 1'b0;
        initErr = 1'b0;
    end
    always @(negedge rasN) begin
        rowLat = multiplexedAddressLines;
        if ($realtime - rowT[rowLat] > REF_NS) begin
            for (int c = 0; c < 256; c++) mem[{rowLat, 8'(c)}] = 1'bx;
        end
        rowT[rowLat] = $realtime;
        if (rasCnt == 0 && $realtime < PWR_NS) initErr = 1'b1;
        rasT = $realtime;
        rasCnt++;
    end
    always @(negedge casN) begin
        colLat = multiplexedAddressLines;
        if (rasCnt < 9) initErr = 1'b1;
        if (wN === 1'b0) begin
            mem[{rowLat, colLat}] = dataIn;
        end else begin
            bitOut = mem[{rowLat, colLat}];
            dataOut = ~bitOut;
            #(CAC_NS);
            if ($realtime < rasT + RAC_NS) #(rasT + RAC_NS - $realtime);
            if (casN === 1'b0) begin
                dataOut = bitOut;
                qDrive = 1'b1;
            end
        end
    end
    always @(negedge wN) begin
        if (casN === 1'b0 && rasN === 1'b0) mem[{rowLat, colLat}] = dataIn;
    end
    // released output shows a wrong level
    always @(posedge casN) begin
        qDrive = 1'b0;
        dataOut = ~dataOut;
    end
endmodule

`default_nettype wire
